//--- mpsl_params.svh
// constants for the mac port pin and strap latch block
`ifndef MPSL_PARAMS_SVH
`define MPSL_PARAMS_SVH
// timing
`define MPSL_CLK_PERIOD_NS  100
`define MPSL_LINK_PERIOD_NS 800
`define MPSL_LINK_HALF_CYC  ((`MPSL_LINK_PERIOD_NS) / (2 * `MPSL_CLK_PERIOD_NS))
// apb register offsets
`define MPSL_CTRL_OFS       12'h000
`define MPSL_STAT_OFS       12'h004
// control register fields and reset value
`define MPSL_CTRL_MII_BIT   0
`define MPSL_CTRL_WAKE_BIT  1
`define MPSL_CTRL_POL_BIT   14
`define MPSL_CTRL_RST       32'h00000000
// status register fields
`define MPSL_ST_ADDR_LSB    0
`define MPSL_ST_MODE_LSB    8
`define MPSL_ST_CLKEN_BIT   12
`define MPSL_ST_LED_BIT     13
`define MPSL_ST_GMII_BIT    14
`define MPSL_ST_NAND_BIT    15
`define MPSL_ST_DONE_BIT    16
// operating mode strap codes
`define MPSL_MODE_GMII      4'h1
`define MPSL_MODE_NAND      4'h4
// positions in the synchronised input vector
`define MPSL_IN_W           22
`define MPSL_IN_TXD         0
`define MPSL_IN_TXEN        8
`define MPSL_IN_TXER        9
`define MPSL_IN_GTX         10
`define MPSL_IN_MDC         11
`define MPSL_IN_MDIO        12
`define MPSL_IN_RXD         13
`define MPSL_IN_RXDV        17
`define MPSL_IN_RXCLK       18
`define MPSL_IN_LED2        19
`define MPSL_IN_LED1        20
`define MPSL_IN_REFCLK      21
`endif

//--- mpsl_pkg.sv
// types for the mac port pin and strap latch block
`default_nettype none
package mpsl_pkg;
  // strap latch sequencer, one-hot
  typedef enum logic [1:0] {
    MPSL_ST_LATCH = 2'b01,
    MPSL_ST_RUN   = 2'b10
  } mpsl_state_t;
endpackage
`default_nettype wire

//--- mpsl_top.sv
// mac facing pin mux, strap latch and apb control of the transceiver
//
// Notes on behaviour
// - gmii takes eight tx bits, mii four
// - mii drives upper rx data bits low
// - mii mode drives transmit clock out
// - rx clock driven, rx data aligned
// - rx error driven in both modes
// - carrier sense and collision driven always
// - straps captured at reset release
// - mode strap from rx data three..zero
// - mode 0001 gmii, 0100 nand tree
// - three bit station address from straps
// - upper two address bits always zero
// - clock enable strap on rx valid pin
// - reference clock out on led strap pin
// - interrupt output, polarity bit, default low
// - wake output asserts low on event
// - interrupt pin always actively driven
// - management data timed to management clock
// - management data output only after reset
// - reset active low with pull up
// - strap high enables reference clock out
// - strap high single led, low dual
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mpsl_params.svh"
module mpsl_top
  import mpsl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  txd,
  input  wire logic        tx_en,
  input  wire logic        tx_er,
  input  wire logic        gtx_clk,
  output logic             tx_clk,
  output logic [7:4]       rxd_hi,
  input  wire logic [3:0]  rxd_lo_i,
  output logic [3:0]       rxd_lo_o,
  output logic [3:0]       rxd_lo_oe,
  input  wire logic        rx_dv_i,
  output logic             rx_dv_o,
  output logic             rx_dv_oe,
  output logic             rx_er,
  input  wire logic        rx_clk_i,
  output logic             rx_clk_o,
  output logic             rx_clk_oe,
  output logic             crs,
  output logic             col,
  input  wire logic        led2_i,
  output logic             led2_o,
  output logic             led2_oe,
  input  wire logic        led1_i,
  output logic             led1_o,
  output logic             led1_oe,
  input  wire logic        refclk_out_pin_i,
  output logic             refclk_out_pin_o,
  output logic             refclk_out_pin_oe,
  output logic             int_wake_out,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  output logic [7:0]       core_txd,
  output logic             core_tx_en,
  output logic             core_tx_er,
  output logic             core_tx_strobe,
  input  wire logic [7:0]  core_rxd,
  input  wire logic        core_rx_dv,
  input  wire logic        core_rx_er,
  input  wire logic        core_crs,
  input  wire logic        core_col,
  output logic             core_rx_take,
  input  wire logic        core_irq,
  input  wire logic        core_wake,
  input  wire logic        core_led2,
  input  wire logic        core_led1,
  input  wire logic        core_mdio_out,
  input  wire logic        core_mdio_drive,
  output logic             core_mdc_rise,
  output logic             core_mdio_bit,
  output logic [4:0]       station_addr,
  output logic             strap_done
);

  // mode strap decode, used for status and for the gmii flag
  function automatic logic mode_is(input logic [3:0] m, input logic [3:0] c);
    mode_is = (m == c);
  endfunction

  // external inputs gathered for the three stage synchroniser
  wire logic [`MPSL_IN_W-1:0] pins_raw;
  assign pins_raw = {refclk_out_pin_i, led1_i, led2_i, rx_clk_i, rx_dv_i,
                     rxd_lo_i, mdio_i, mdc, gtx_clk, tx_er, tx_en, txd};

  logic [`MPSL_IN_W-1:0] sync1_ff;   // metastability catcher, read by sync2
  logic [`MPSL_IN_W-1:0] sync2_ff;   // second stage
  logic [`MPSL_IN_W-1:0] sync3_ff;   // third stage
  logic [`MPSL_IN_W-1:0] clean_ff;   // agreed value
  wire  logic [`MPSL_IN_W-1:0] agree;

  // a bit changes only once stages two and three agree
  assign agree = ~(sync2_ff ^ sync3_ff);

  // no reset here: the chain must track pin levels through reset so the
  // strap values are ready at the first edge after release
  always_ff @(posedge pclk) begin
    sync1_ff <= pins_raw;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
    clean_ff <= (agree & sync3_ff) | (~agree & clean_ff);
  end

  // strap sequencer and latched straps
  mpsl_state_t state_ff;
  mpsl_state_t nxt_state;
  logic [3:0]  mode_strap_ff;        // op_select_strap_bit3..0
  logic [2:0]  addr_strap_ff;        // station_addr_strap
  logic        clken_strap_ff;       // refclk_out_enable_strap
  logic        led_strap_ff;         // indicator_style_strap
  wire  logic  latching;
  wire  logic  running;

  assign latching = (state_ff == MPSL_ST_LATCH);
  assign running  = (state_ff == MPSL_ST_RUN);

  // one pass through latch, then run until reset comes back
  always_comb begin
    case (state_ff)
      MPSL_ST_LATCH: nxt_state = MPSL_ST_RUN;
      MPSL_ST_RUN:   nxt_state = MPSL_ST_RUN;
      default:       nxt_state = MPSL_ST_LATCH;
    endcase
  end

  // presetn is the chip reset; its pull-up lives in the pad ring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MPSL_ST_LATCH;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // capture straps on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_strap_ff  <= 4'h0;
      addr_strap_ff  <= 3'h0;
      clken_strap_ff <= 1'b0;
      led_strap_ff   <= 1'b0;
    end else if (latching) begin
      // only latch: later pin activity never touches these
      mode_strap_ff  <= clean_ff[`MPSL_IN_RXD +: 4];
      addr_strap_ff  <= {clean_ff[`MPSL_IN_RXCLK],
                         clean_ff[`MPSL_IN_LED2],
                         clean_ff[`MPSL_IN_LED1]};
      clken_strap_ff <= clean_ff[`MPSL_IN_RXDV];
      led_strap_ff   <= clean_ff[`MPSL_IN_REFCLK];
    end
  end

  // decoded mode; reserved codes leave both flags low
  wire logic gmii_ok;
  wire logic nand_mode;
  assign gmii_ok   = mode_is(mode_strap_ff, `MPSL_MODE_GMII);
  assign nand_mode = mode_is(mode_strap_ff, `MPSL_MODE_NAND);

  // upper address bits forced to zero
  assign station_addr = {2'b00, addr_strap_ff};
  assign strap_done   = running;

  // apb slave, zero wait states
  logic [31:0] ctrl_ff;              // mii select, wake select, polarity
  wire  logic  hit_ctrl;
  wire  logic  hit_stat;
  wire  logic  apb_acc;
  wire  logic  mii;
  wire  logic  wake_sel;
  wire  logic  int_pol;
  wire  logic [31:0] stat_word;

  assign apb_acc  = psel & penable;
  assign hit_ctrl = (paddr == `MPSL_CTRL_OFS);
  assign hit_stat = (paddr == `MPSL_STAT_OFS);
  assign mii      = ctrl_ff[`MPSL_CTRL_MII_BIT];
  assign wake_sel = ctrl_ff[`MPSL_CTRL_WAKE_BIT];
  assign int_pol  = ctrl_ff[`MPSL_CTRL_POL_BIT];   // 0 active low
  assign pready   = 1'b1;
  assign pslverr  = apb_acc & ~hit_ctrl & ~hit_stat;

  // status word shows latched straps and decoded mode
  assign stat_word = (32'(station_addr) << `MPSL_ST_ADDR_LSB)
                   | (32'(mode_strap_ff) << `MPSL_ST_MODE_LSB)
                   | (32'(clken_strap_ff) << `MPSL_ST_CLKEN_BIT)
                   | (32'(led_strap_ff) << `MPSL_ST_LED_BIT)
                   | (32'(gmii_ok) << `MPSL_ST_GMII_BIT)
                   | (32'(nand_mode) << `MPSL_ST_NAND_BIT)
                   | (32'(running) << `MPSL_ST_DONE_BIT);
  assign prdata = !psel ? 32'h00000000 :
                  hit_ctrl ? ctrl_ff :
                  hit_stat ? stat_word : 32'h00000000;

  // only the three defined control bits are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `MPSL_CTRL_RST;
    end else if (apb_acc && pwrite && hit_ctrl) begin
      ctrl_ff <= pwdata & ((32'h1 << `MPSL_CTRL_MII_BIT)
                         | (32'h1 << `MPSL_CTRL_WAKE_BIT)
                         | (32'h1 << `MPSL_CTRL_POL_BIT));
    end
  end

  // link clock divider: 800 ns period from the 100 ns clock
  localparam int HALF = `MPSL_LINK_HALF_CYC;
  logic [3:0] div_ff;                // half period counter
  logic       link_clk_ff;           // divided clock level
  wire  logic div_tick;
  assign div_tick = (div_ff == 4'(HALF - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff      <= 4'h0;
      link_clk_ff <= 1'b0;
    end else begin
      div_ff      <= div_tick ? 4'h0 : div_ff + 4'h1;
      link_clk_ff <= div_tick ? ~link_clk_ff : link_clk_ff;
    end
  end

  // transmit clock out only in mii; gmii takes it from the mac
  assign tx_clk = running & mii & link_clk_ff;

  // transmit capture: gtx edge in gmii, own clock rise in mii
  logic gtx_prev_ff;                 // last clean gtx level
  logic mdc_prev_ff;                 // last clean mdc level
  wire  logic gtx_rise;
  wire  logic mii_rise;
  wire  logic tx_take;
  assign gtx_rise = clean_ff[`MPSL_IN_GTX] & ~gtx_prev_ff;
  assign mii_rise = div_tick & ~link_clk_ff;
  assign tx_take  = running & (mii ? mii_rise : gtx_rise);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gtx_prev_ff <= 1'b0;
      mdc_prev_ff <= 1'b0;
    end else begin
      gtx_prev_ff <= clean_ff[`MPSL_IN_GTX];
      mdc_prev_ff <= clean_ff[`MPSL_IN_MDC];
    end
  end

  // latch transmit word; tx error simply passes, as the mac drives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_txd       <= 8'h00;
      core_tx_en     <= 1'b0;
      core_tx_er     <= 1'b0;
      core_tx_strobe <= 1'b0;
    end else begin
      core_tx_strobe <= tx_take;
      if (tx_take) begin
        // upper nibble ignored in mii whatever the mac drives
        core_txd   <= {mii ? 4'h0 : clean_ff[`MPSL_IN_TXD + 4 +: 4],
                       clean_ff[`MPSL_IN_TXD +: 4]};
        core_tx_en <= clean_ff[`MPSL_IN_TXEN];
        core_tx_er <= clean_ff[`MPSL_IN_TXER];
      end
    end
  end

  // receive side: data changes as rx clock falls, stable at its rise
  wire logic rx_load;
  assign rx_load = running & div_tick & link_clk_ff;
  assign core_rx_take = rx_load;

  logic [7:0] rxd_ff;                // receive data toward mac
  logic       rx_dv_ff;              // receive data valid
  logic       rx_er_ff;              // receive error
  logic       crs_ff;                // carrier sense
  logic       col_ff;                // collision

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_ff   <= 8'h00;
      rx_dv_ff <= 1'b0;
      rx_er_ff <= 1'b0;
    end else if (rx_load) begin
      rxd_ff   <= {mii ? 4'h0 : core_rxd[7:4], core_rxd[3:0]};
      rx_dv_ff <= core_rx_dv;
      rx_er_ff <= core_rx_er;
    end
  end

  // carrier and collision are asynchronous to frames, follow each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_ff <= 1'b0;
      col_ff <= 1'b0;
    end else begin
      crs_ff <= running & core_crs;
      col_ff <= running & core_col;
    end
  end

  assign rxd_hi   = rxd_ff[7:4];
  assign rxd_lo_o = rxd_ff[3:0];
  assign rx_dv_o  = rx_dv_ff;
  assign rx_er    = rx_er_ff;
  assign crs      = crs_ff;
  assign col      = col_ff;
  assign rx_clk_o = link_clk_ff;

  // shared strap pins stay released until the latch is done
  assign rxd_lo_oe = {4{running}};
  assign rx_dv_oe  = running;
  assign rx_clk_oe = running;
  assign led2_oe   = running;
  assign led1_oe   = running;
  assign led2_o    = core_led2;
  assign led1_o    = core_led1;

  // reference clock out, half pclk rate stand-in for the 125 MHz source
  logic refclk_ff;                   // free toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclk_ff <= 1'b0;
    end else begin
      refclk_ff <= ~refclk_ff;
    end
  end
  assign refclk_out_pin_o  = refclk_ff;
  assign refclk_out_pin_oe = running & clken_strap_ff;

  // interrupt or wake, push-pull: no open-drain mode exists
  logic int_ff;                      // pin level
  wire  logic nxt_int;
  assign nxt_int = wake_sel ? ~core_wake
                            : (core_irq ? int_pol : ~int_pol);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ff <= 1'b1;                // idle high for default low polarity
    end else begin
      int_ff <= nxt_int;
    end
  end
  assign int_wake_out = int_ff;

  // management: data sampled on clean mdc rise
  logic mdio_bit_ff;                 // last sampled management bit
  assign core_mdc_rise = running & clean_ff[`MPSL_IN_MDC] & ~mdc_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_bit_ff <= 1'b1;           // pulled-up idle level
    end else if (core_mdc_rise) begin
      mdio_bit_ff <= clean_ff[`MPSL_IN_MDIO];
    end
  end
  assign core_mdio_bit = mdio_bit_ff;
  // pin is an input with pull-up until after reset
  assign mdio_o  = core_mdio_out;
  assign mdio_oe = running & core_mdio_drive;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_mii_hi;
    (tx_take && mii) |=> (core_txd[7:4] == 4'h0) && core_tx_strobe;
  endproperty
  a_tx_mii_hi: assert property (p_tx_mii_hi)
    else $error("mii upper tx bits not ignored");

  property p_rx_mii_hi;
    (rx_load && mii) |=> (rxd_hi == 4'h0) [*8];
  endproperty
  a_rx_mii_hi: assert property (p_rx_mii_hi)
    else $error("mii upper rx bits not low");

  property p_tx_clk;
    (running && mii && div_tick) ##1 mii |-> (tx_clk != $past(tx_clk));
  endproperty
  a_tx_clk: assert property (p_tx_clk)
    else $error("mii tx clock not toggling");

  property p_rx_align;
    $changed(rxd_ff) |-> $fell(rx_clk_o);
  endproperty
  a_rx_align: assert property (p_rx_align)
    else $error("rx data changed off falling rx clock");

  property p_crs;
    running |=> (crs == $past(core_crs)) && (col == $past(core_col));
  endproperty
  a_crs: assert property (p_crs)
    else $error("carrier or collision not forwarded");

  property p_latch;
    latching |=> (mode_strap_ff == $past(clean_ff[`MPSL_IN_RXD +: 4]))
                 && running;
  endproperty
  a_latch: assert property (p_latch)
    else $error("mode strap not captured at release");

  property p_hold;
    running |=> $stable(mode_strap_ff) && $stable(addr_strap_ff)
                && $stable(clken_strap_ff) && $stable(led_strap_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched strap changed after release");

  property p_pins_off;
    latching |-> (rxd_lo_oe == 4'h0) && !rx_dv_oe && !rx_clk_oe
                 && !led1_oe && !led2_oe && !refclk_out_pin_oe && !mdio_oe;
  endproperty
  a_pins_off: assert property (p_pins_off)
    else $error("shared pin driven before strap latch");

  property p_int;
    (!wake_sel && core_irq) |=> (int_wake_out == $past(int_pol));
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt level wrong for polarity");

  property p_wake;
    (wake_sel && core_wake) |=> !int_wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake event not shown low");

  c_strap_done: cover property (latching ##1 running);
  c_gmii_tx:    cover property (tx_take && !mii);
  c_mii_tx:     cover property (tx_take && mii);
  c_wake:       cover property (wake_sel && core_wake ##1 !int_wake_out);

endmodule
`default_nettype wire

//--- mpsl_mac_model.sv
// mac side partner model for the mac port pins
`timescale 1ns/1ps
`default_nettype none
module mpsl_mac_model (
  input  wire logic       tx_clk,
  input  wire logic       rx_clk_o,
  input  wire logic [7:4] rxd_hi,
  input  wire logic [3:0] rxd_lo_o,
  input  wire logic       rx_dv_o,
  input  wire logic       rx_er,
  output logic            gtx_clk,
  output logic [7:0]      txd,
  output logic            tx_en,
  output logic            tx_er,
  output logic [9:0]      rx_seen
);
  // gigabit clock stands low between frames
  initial begin
    gtx_clk = 1'b0;
    txd     = 8'h00;
    tx_en   = 1'b0;
    tx_er   = 1'b0; // held low unless a test asks for an error
  end
  // receive side samples on the rising receive clock
  always @(posedge rx_clk_o) begin
    rx_seen <= {rx_er, rx_dv_o, rxd_hi, rxd_lo_o};
  end
  // one byte; in mii the upper nibble goes out as given
  task automatic send(input logic [7:0] d, input logic en,
                      input logic er, input logic mii);
    if (mii) begin
      @(posedge tx_clk); // launch on a rise, device takes it next
      {txd, tx_en, tx_er} = {d, en, er};
      @(posedge tx_clk);
    end else begin
      #137; // phase unrelated to the system clock
      {txd, tx_en, tx_er} = {d, en, er};
      #400 gtx_clk = 1'b1; // data launched in the gigabit domain
      #400 gtx_clk = 1'b0;
    end
    // released bus shows the inverse, never the old byte
    txd   = ~d;
    tx_en = 1'b0;
    tx_er = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- mpsl_tb_top.sv
// self-checking bench for the mac port pin mux and strap latch
`timescale 1ns/1ps
`default_nettype none
`include "mpsl_params.svh"
module mpsl_tb_top;
  // one strap setting and the status word it should give
  typedef struct packed {
    logic [3:0]  mode;
    logic [2:0]  addr;
    logic        clken;
    logic        led;
    logic [31:0] stat;
  } mpsl_row_t;
  mpsl_row_t   rows [4] = '{'{4'h4, 3'h2, 1'b0, 1'b0, 32'h00018402},
                            '{4'h0, 3'h7, 1'b1, 1'b0, 32'h00011007},
                            '{4'h6, 3'h0, 1'b0, 1'b1, 32'h00012600},
                            '{4'h1, 3'h5, 1'b1, 1'b1, 32'h00017105}};
  // {wake select, polarity, irq, wake, expected pin}
  logic [4:0]  irow [4] = '{5'h04, 5'h01, 5'h0D, 5'h12};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [7:0]  txd, core_txd;
  logic [7:0]  core_rxd = 8'h00;
  logic [7:4]  rxd_hi;
  logic [3:0]  rxd_lo_i, rxd_lo_o, rxd_lo_oe;
  logic        tx_en, tx_er, gtx_clk, tx_clk, rx_er, crs, col;
  logic        rx_dv_i, rx_dv_o, rx_dv_oe, rx_clk_i, rx_clk_o, rx_clk_oe;
  logic        led2_i, led2_o, led2_oe, led1_i, led1_o, led1_oe;
  logic        refclk_out_pin_i, refclk_out_pin_o, refclk_out_pin_oe;
  logic        int_wake_out, mdio_i, mdio_o, mdio_oe, strap_done;
  logic        core_tx_en, core_tx_er, core_tx_strobe, core_rx_take;
  logic        core_mdc_rise, core_mdio_bit;
  logic [4:0]  station_addr;
  logic [9:0]  rx_seen;
  logic        mdc = 1'b0;
  logic        core_rx_dv = 1'b0;
  logic        core_rx_er = 1'b0;
  logic        core_crs = 1'b0;
  logic        core_col = 1'b0;
  logic        core_irq = 1'b0;
  logic        core_wake = 1'b0;
  logic        core_led2 = 1'b0;
  logic        core_led1 = 1'b0;
  logic        core_mdio_out = 1'b0;
  logic        core_mdio_drive = 1'b0;
  logic [3:0]  mode_pull = 4'h1;  // board pulls on shared pins
  logic [2:0]  addr_pull = 3'h0;
  logic        clken_pull = 1'b0;
  logic        led_pull = 1'b0;
  logic        ms_val = 1'b1;     // station drive, pull-up when idle
  int          error_cnt = 0;
  int          check_count = 0;
  // events waited on: mdc rise, receive take, transmit strobe
  wire [2:0]   evt = {core_mdc_rise, core_rx_take,
                      core_tx_strobe & core_tx_en};

  // shared pins: device drive wins, otherwise the pull level
  assign rxd_lo_i = (rxd_lo_oe & rxd_lo_o) | (~rxd_lo_oe & mode_pull);
  assign rx_dv_i  = rx_dv_oe ? rx_dv_o : clken_pull;
  assign rx_clk_i = rx_clk_oe ? rx_clk_o : addr_pull[2];
  assign led2_i   = led2_oe ? led2_o : addr_pull[1];
  assign led1_i   = led1_oe ? led1_o : addr_pull[0];
  assign refclk_out_pin_i = refclk_out_pin_oe ? refclk_out_pin_o : led_pull;
  assign mdio_i   = mdio_oe ? mdio_o : ms_val;

  always #50 pclk = ~pclk;
  mpsl_top       dut (.*);
  mpsl_mac_model mac (.*);

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // bounded wait on one event, sampled mid-cycle
  task automatic wait_evt(input int k);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (evt[k] !== 1'b1 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      $display("MISMATCH event %0d exp 1 seen 0", k);
    end
  endtask
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset with given pulls; shared pins must float meanwhile
  task automatic do_reset(input mpsl_row_t r);
    @(posedge pclk);
    presetn    <= 1'b0;
    mode_pull  <= r.mode;
    addr_pull  <= r.addr;
    clken_pull <= r.clken;
    led_pull   <= r.led;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("oe_in_reset", {rxd_lo_oe, rx_dv_oe, rx_clk_oe, led2_oe, led1_oe,
        refclk_out_pin_oe, mdio_oe}, 32'h0);
    chk("int_in_reset", int_wake_out, 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("oe_run", {strap_done, rxd_lo_oe, rx_dv_oe, rx_clk_oe, led2_oe,
        led1_oe}, 32'h1FF);
  endtask

  // watchdog: the whole run needs about a hundred and thirty cycles
  initial begin
    #1_000_000;
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end

  // main sequence
  initial begin
    // strap rows, last one leaves gmii/mii mode latched
    foreach (rows[i]) begin
      do_reset(rows[i]);
      apb(1'b0, `MPSL_STAT_OFS, 32'h0);
      chk("status", rd, rows[i].stat);
      chk("mode", rd[`MPSL_ST_MODE_LSB +: 4], rows[i].mode);
      chk("style", rd[`MPSL_ST_LED_BIT], rows[i].led);
      chk("station_addr", station_addr, {2'b00, rows[i].addr});
      chk("refclk_oe", refclk_out_pin_oe, rows[i].clken);
    end
    // reference clock toggles on the strap pin
    @(negedge pclk);
    rd[0] = refclk_out_pin_o;
    @(negedge pclk);
    chk("refclk_toggle", refclk_out_pin_o ^ rd[0], 32'h1);
    // control reset value, unmapped place, read-only status
    apb(1'b0, `MPSL_CTRL_OFS, 32'h0);
    chk("ctrl_reset", rd, `MPSL_CTRL_RST);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk("unmapped_wr_err", err, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_rd", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, `MPSL_STAT_OFS, 32'h0);
    // gigabit transmit, plain and with error
    fork
      mac.send(8'hA5, 1'b1, 1'b0, 1'b0);
      begin
        wait_evt(0);
        chk("gmii_tx", {core_tx_er, core_txd}, 32'h0A5);
      end
    join
    fork
      mac.send(8'h3C, 1'b1, 1'b1, 1'b0);
      begin
        wait_evt(0);
        chk("gmii_tx_er", {core_tx_er, core_txd}, 32'h13C);
      end
    join
    chk("tx_clk_gmii", tx_clk, 32'h0);
    // mii transmit: upper nibble ignored
    apb(1'b1, `MPSL_CTRL_OFS, 32'h1);
    fork
      mac.send(8'hF3, 1'b1, 1'b0, 1'b1);
      begin
        wait_evt(0);
        chk("mii_txd", core_txd, 32'h03);
      end
    join
    // receive in gmii then mii
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `MPSL_CTRL_OFS, {31'h0, m[0]});
      core_rxd   <= 8'hC6;
      core_rx_dv <= 1'b1;
      core_rx_er <= m[0];
      core_crs   <= 1'b1;
      core_col   <= ~m[0];
      wait_evt(1);
      @(posedge rx_clk_o);
      #1;
      chk("rx_seen", rx_seen,
          {m[0], 1'b1, m[0] ? 4'h0 : 4'hC, 4'h6});
      chk("crs_col", {crs, col}, {1'b1, ~m[0]});
    end
    // interrupt polarity and wake select
    foreach (irow[i]) begin
      apb(1'b1, `MPSL_CTRL_OFS, {17'h0, irow[i][3], 12'h0, irow[i][4], 1'b0});
      core_irq  <= irow[i][2];
      core_wake <= irow[i][1];
      repeat (2) @(negedge pclk);
      chk("int_wake", int_wake_out, irow[i][0]);
    end
    // management bit sampled on mdc rise
    @(posedge pclk);
    ms_val <= 1'b0;
    @(posedge pclk);
    mdc    <= 1'b1; // data set up a cycle before the clock rise
    wait_evt(2);
    @(negedge pclk);
    chk("mdio_bit", core_mdio_bit, 32'h0);
    @(posedge pclk);
    mdc             <= 1'b0;
    ms_val          <= 1'b1;
    core_mdio_drive <= 1'b1;
    core_led2       <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("mdio_led", {mdio_oe, mdio_o, led2_o, led1_o}, 32'hA);
    // straps unchanged by traffic and the status write
    apb(1'b0, `MPSL_STAT_OFS, 32'h0);
    chk("status_hold", rd, 32'h00017105);
    summarize();
  end
endmodule
`default_nettype wire
